/* File: include/lpm_map.svh */
`ifndef LPM_MAP_SVH
`define LPM_MAP_SVH

// number of gated peripheral clock enables
`define LPM_NUM_PERIPH        8
// clock period and the two wake-up times, in nanoseconds
`define LPM_CLK_PERIOD_NS     100
`define LPM_OSC_RESTART_NS    400000
`define LPM_OSC_KEPT_WAKE_NS  2000
// width of the wake-up counter
`define LPM_WAKE_CNT_W        12
// reset values and the peripheral all-off pattern
`define LPM_CFG_RESET         1'b0
`define LPM_CNT_RESET         12'h000
`define LPM_PERIPH_ALL_ON     8'hff
`define LPM_PERIPH_ALL_OFF    8'h00

`endif

/* File: include/lpm_pkg.sv */
`default_nettype none
`include "lpm_map.svh"

package lpm_pkg;

  // power mode states
  typedef enum logic [2:0] {
    LPM_RUN       = 3'b000,
    LPM_IDLE      = 3'b001,
    LPM_FULL_HALT = 3'b010,
    LPM_OSC_HALT  = 3'b011,
    LPM_WAKE      = 3'b100
  } lpm_state_type;

  // clock enables that leave the controller together
  typedef struct packed {
    logic                       osc;
    logic                       sys;
    logic                       cpu;
    logic                       tick;
    logic                       wdog;
    logic [`LPM_NUM_PERIPH-1:0] periph;
  } lpm_clk_en_type;

  // reset request sources
  typedef struct packed {
    logic pin_n;
    logic clock_reset_generator;
    logic low_voltage_reset_request;
  } lpm_rst_req_type;

endpackage

`default_nettype wire

/* File: rtl/lpm_ctrl.sv */
`default_nettype none
`include "lpm_map.svh"

module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter int NUM_PERIPH   = `LPM_NUM_PERIPH,
  parameter int OSC_RESTART_NS = `LPM_OSC_RESTART_NS,
  parameter int OSC_KEPT_NS  = `LPM_OSC_KEPT_WAKE_NS
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire lpm_rst_req_type       rst_req,
  input  wire logic                  halt_instr,
  input  wire logic                  idle_wait_instruction,
  input  wire logic                  cfg_wr,
  input  wire logic                  cfg_osc_kept,
  input  wire logic                  ext_irq,
  input  wire logic                  any_irq,
  input  wire logic                  tick_keep,
  input  wire logic                  wdog_keep,
  input  wire logic [NUM_PERIPH-1:0] periph_idle_gate,
  input  wire logic                  nv_unsecured,
  output lpm_clk_en_type             clk_en_q,
  output logic                       bus_hold_q,
  output logic                       sys_rst_q,
  output logic                       secured_q,
  output logic                       ram_clear_q,
  output lpm_state_type              state_q
);

  // wake counts: a least time, so round up
  localparam int FULL_WAKE_CYC =
    (OSC_RESTART_NS + `LPM_CLK_PERIOD_NS - 1) / `LPM_CLK_PERIOD_NS;
  localparam int OSC_WAKE_CYC =
    (OSC_KEPT_NS + `LPM_CLK_PERIOD_NS - 1) / `LPM_CLK_PERIOD_NS;
  localparam logic [`LPM_WAKE_CNT_W-1:0] FULL_WAKE_LD = FULL_WAKE_CYC[`LPM_WAKE_CNT_W-1:0];
  localparam logic [`LPM_WAKE_CNT_W-1:0] OSC_WAKE_LD  = OSC_WAKE_CYC[`LPM_WAKE_CNT_W-1:0];
  localparam logic [`LPM_WAKE_CNT_W-1:0] CNT_ONE      = `LPM_WAKE_CNT_W'(1);

  // elaboration checks
  if (NUM_PERIPH != `LPM_NUM_PERIPH) begin : g_bad_width
    $error("NUM_PERIPH must match the clock enable struct");
  end
  if (FULL_WAKE_CYC >= (1 << `LPM_WAKE_CNT_W) || OSC_WAKE_CYC < 1 ||
      OSC_WAKE_CYC >= FULL_WAKE_CYC) begin : g_bad_wake
    $error("wake counts out of range or not ordered");
  end

  logic                      any_rst;
  logic                      halt_sel_q;
  logic [`LPM_WAKE_CNT_W-1:0] wake_cnt_q;
  lpm_state_type             state_d;
  lpm_clk_en_type            clk_en_d;

  // merge of all reset requests
  // four reset sources: rst plus the three request lines
  assign any_rst = rst || !rst_req.pin_n || rst_req.clock_reset_generator ||
                   rst_req.low_voltage_reset_request;

  // registered system reset out
  always_ff @(posedge core_clk) begin
    sys_rst_q <= any_rst;
  end

  // halt flavour select
  // select bit, full halt out of reset
  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      halt_sel_q <= `LPM_CFG_RESET;
    end else if (cfg_wr && state_q == LPM_RUN) begin
      halt_sel_q <= cfg_osc_kept;
    end
  end

  // mode sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      LPM_RUN: begin
        if (halt_instr) begin
          state_d = halt_sel_q ? LPM_OSC_HALT : LPM_FULL_HALT;
        end else if (idle_wait_instruction) begin
          state_d = LPM_IDLE;
        end
      end
      LPM_IDLE: begin
        if (any_irq) begin
          state_d = LPM_RUN;
        end
      end
      LPM_FULL_HALT: begin
        // only an external interrupt (or reset) leaves it
        if (ext_irq) begin
          state_d = LPM_WAKE;
        end
      end
      LPM_OSC_HALT: begin
        if (any_irq) begin
          state_d = LPM_WAKE;
        end
      end
      LPM_WAKE: begin
        if (wake_cnt_q == CNT_ONE) begin
          state_d = LPM_RUN;
        end
      end
      default: state_d = LPM_RUN;
    endcase
  end

  // state register
  // start-up state on any reset
  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      state_q <= LPM_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // wake-up delay counter
  // short wake when oscillator kept
  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      wake_cnt_q <= `LPM_CNT_RESET;
    end else if (state_q == LPM_FULL_HALT && ext_irq) begin
      wake_cnt_q <= FULL_WAKE_LD;
    end else if (state_q == LPM_OSC_HALT && any_irq) begin
      wake_cnt_q <= OSC_WAKE_LD;
    end else if (state_q == LPM_WAKE && wake_cnt_q != `LPM_CNT_RESET) begin
      wake_cnt_q <= wake_cnt_q - CNT_ONE;
    end
  end

  // wake bookkeeping for the checks: which halt is being left
  logic                       wake_osc_q;
  logic [`LPM_WAKE_CNT_W-1:0] wake_len_q;

  // remember the flavour of the halt that the wake-up came from
  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      wake_osc_q <= 1'b0;
    end else if (state_q == LPM_OSC_HALT && any_irq) begin
      wake_osc_q <= 1'b1;
    end else if (state_q == LPM_FULL_HALT && ext_irq) begin
      wake_osc_q <= 1'b0;
    end
  end

  // cycles spent in wake so far, cleared one cycle after wake is left
  always_ff @(posedge core_clk) begin
    if (any_rst || state_q != LPM_WAKE) begin
      wake_len_q <= `LPM_CNT_RESET;
    end else begin
      wake_len_q <= wake_len_q + CNT_ONE;
    end
  end

  // clock enables for the next state
  always_comb begin
    clk_en_d.osc    = 1'b1;
    clk_en_d.sys    = 1'b1;
    clk_en_d.cpu    = 1'b1;
    clk_en_d.tick   = 1'b1;
    clk_en_d.wdog   = 1'b1;
    clk_en_d.periph = `LPM_PERIPH_ALL_ON;
    case (state_d)
      LPM_RUN: begin
        clk_en_d.cpu = 1'b1;
      end
      LPM_IDLE: begin
        clk_en_d.cpu    = 1'b0;
        clk_en_d.periph = ~periph_idle_gate;
      end
      LPM_FULL_HALT: begin
        clk_en_d.osc    = 1'b0;
        clk_en_d.sys    = 1'b0;
        clk_en_d.cpu    = 1'b0;
        clk_en_d.tick   = 1'b0;
        clk_en_d.wdog   = 1'b0;
        clk_en_d.periph = `LPM_PERIPH_ALL_OFF;
      end
      LPM_OSC_HALT: begin
        // oscillator on, tick and watchdog optional
        clk_en_d.sys    = 1'b0;
        clk_en_d.cpu    = 1'b0;
        clk_en_d.tick   = tick_keep;
        clk_en_d.wdog   = wdog_keep;
        clk_en_d.periph = `LPM_PERIPH_ALL_OFF;
      end
      LPM_WAKE: begin
        // oscillator settles before anything else restarts
        clk_en_d.sys    = 1'b0;
        clk_en_d.cpu    = 1'b0;
        clk_en_d.tick   = 1'b0;
        clk_en_d.wdog   = 1'b0;
        clk_en_d.periph = `LPM_PERIPH_ALL_OFF;
      end
      default: clk_en_d.cpu = 1'b1;
    endcase
  end

  // clock enable outputs
  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      clk_en_q <= '{osc: 1'b1, sys: 1'b1, cpu: 1'b1, tick: 1'b1, wdog: 1'b1,
                    periph: `LPM_PERIPH_ALL_ON};
    end else begin
      clk_en_q <= clk_en_d;
    end
  end

  // core bus freeze
  // buses static in idle wait
  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      bus_hold_q <= 1'b0;
    end else begin
      bus_hold_q <= (state_d == LPM_IDLE);
    end
  end

  // security state taken at each reset
  // secured again unless unsecure was programmed
  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      secured_q <= !nv_unsecured;
    end
  end

  // ram is never touched by reset
  // no ram clear on reset
  always_ff @(posedge core_clk) begin
    ram_clear_q <= 1'b0;
  end

  // checks
  a_full_halt_off: assert property (@(posedge core_clk) disable iff (any_rst)
    state_q == LPM_FULL_HALT |-> !clk_en_q.osc && !clk_en_q.sys && clk_en_q.periph == '0)
    else $error("clock still enabled in full halt");

  a_full_halt_exit: assert property (@(posedge core_clk) disable iff (any_rst)
    state_q == LPM_FULL_HALT && !ext_irq |=> state_q == LPM_FULL_HALT)
    else $error("full halt left without interrupt");

  a_halt_select: assert property (@(posedge core_clk) disable iff (any_rst)
    state_q == LPM_RUN && halt_instr |=>
      state_q == ($past(halt_sel_q) ? LPM_OSC_HALT : LPM_FULL_HALT))
    else $error("halt instruction took wrong flavour");

  a_sel_reset: assert property (@(posedge core_clk)
    any_rst |=> !halt_sel_q)
    else $error("halt select not full halt after reset");

  a_osc_kept: assert property (@(posedge core_clk) disable iff (any_rst)
    state_q == LPM_OSC_HALT |-> clk_en_q.osc && clk_en_q.periph == '0 && !clk_en_q.cpu)
    else $error("oscillator-kept halt clocks wrong");

  a_osc_wake_time: assert property (@(posedge core_clk) disable iff (any_rst)
    state_q == LPM_WAKE && wake_osc_q && wake_len_q == OSC_WAKE_LD - CNT_ONE |=>
      state_q == LPM_RUN)
    else $error("oscillator-kept wake time wrong");

  a_full_wake_min: assert property (@(posedge core_clk) disable iff (any_rst)
    state_q == LPM_WAKE && !wake_osc_q && wake_len_q < FULL_WAKE_LD - CNT_ONE |=>
      state_q == LPM_WAKE)
    else $error("full halt wake ended too early");

  a_idle_clocks: assert property (@(posedge core_clk) disable iff (any_rst)
    state_q == LPM_RUN && !halt_instr && idle_wait_instruction |=>
      !clk_en_q.cpu && clk_en_q.sys && bus_hold_q &&
      clk_en_q.periph == ~$past(periph_idle_gate))
    else $error("idle wait clocks or bus hold wrong");

  a_reset_merge: assert property (@(posedge core_clk)
    !rst_req.pin_n || rst_req.clock_reset_generator ||
      rst_req.low_voltage_reset_request |=> sys_rst_q)
    else $error("reset request not forwarded");

  a_ram_kept: assert property (@(posedge core_clk)
    sys_rst_q |-> !ram_clear_q)
    else $error("ram clear during reset");

  a_secure_reset: assert property (@(posedge core_clk)
    any_rst && !nv_unsecured |=> secured_q)
    else $error("part not secured after reset");

endmodule

`default_nettype wire

/* File: testbench/lpm_core_model.sv */
`default_nettype none

// processor core side: issues halt, idle-wait and halt-select requests
module lpm_core_model (
  input  wire logic core_clk,
  output var logic  halt_instr,
  output var logic  idle_wait_instruction,
  output var logic  cfg_wr,
  output var logic  cfg_osc_kept
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    halt_instr = 1'b0;
    idle_wait_instruction = 1'b0;
    cfg_wr = 1'b0;
    cfg_osc_kept = 1'b0;
  end

  // one-cycle instruction pulse, launched just after an edge
  task automatic pulse(input logic halt);
    @(posedge core_clk);
    if (halt) begin
      halt_instr <= 1'b1;
    end else begin
      idle_wait_instruction <= 1'b1;
    end
    @(posedge core_clk);
    halt_instr <= 1'b0;
    idle_wait_instruction <= 1'b0;
  endtask

  // halt-select write; data inverted once the strobe drops
  task automatic set_sel(input logic kept);
    @(posedge core_clk);
    cfg_wr <= 1'b1;
    cfg_osc_kept <= kept;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    cfg_osc_kept <= ~kept;
  endtask
endmodule

`default_nettype wire

/* File: testbench/low_power_mode_and_reset_control_tb_top.sv */
`default_nettype none

module low_power_mode_and_reset_control_tb_top;
  import lpm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int FULL_CYC = 1000 / 100;
  localparam int KEPT_CYC = 200 / 100;
  logic            core_clk = 1'b0;
  logic            rst;
  lpm_rst_req_type rst_req;
  logic            ext_irq;
  logic            any_irq;
  logic            tick_keep;
  logic            wdog_keep;
  logic            nv_unsecured;
  logic [7:0]      gate;
  logic            halt_instr;
  logic            idle_wait_instruction;
  logic            cfg_wr;
  logic            cfg_osc_kept;
  lpm_clk_en_type  clk_en_q;
  logic            bus_hold_q;
  logic            sys_rst_q;
  logic            secured_q;
  logic            ram_clear_q;
  lpm_state_type   state_q;
  int              err_total = 0;
  int              tests_run = 0;
  int              cyc = 0;
  int              full_n = 0;

  always #50 core_clk = ~core_clk;

  lpm_core_model u_core (.core_clk(core_clk), .halt_instr(halt_instr),
    .idle_wait_instruction(idle_wait_instruction), .cfg_wr(cfg_wr),
    .cfg_osc_kept(cfg_osc_kept));

  lpm_ctrl #(.OSC_RESTART_NS(1000), .OSC_KEPT_NS(200)) u_dut (.core_clk(core_clk),
    .rst(rst), .rst_req(rst_req), .halt_instr(halt_instr),
    .idle_wait_instruction(idle_wait_instruction), .cfg_wr(cfg_wr),
    .cfg_osc_kept(cfg_osc_kept), .ext_irq(ext_irq), .any_irq(any_irq),
    .tick_keep(tick_keep), .wdog_keep(wdog_keep), .periph_idle_gate(gate),
    .nv_unsecured(nv_unsecured), .clk_en_q(clk_en_q), .bus_hold_q(bus_hold_q),
    .sys_rst_q(sys_rst_q), .secured_q(secured_q), .ram_clear_q(ram_clear_q),
    .state_q(state_q));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // cycles until the controller is back in run, bounded
  task automatic wait_run(output int n);
    n = 0;
    while (state_q !== LPM_RUN && n < 100) begin
      tick(1);
      n++;
    end
  endtask

  task automatic t_full;
    int n;
    u_core.pulse(1'b1);
    #1;
    chk("full state", 16'(LPM_FULL_HALT), 16'(state_q));
    chk("full clocks", 16'h0000, 16'(clk_en_q));
    @(posedge core_clk);
    any_irq <= 1'b1;
    tick(3);
    chk("full ignores irq", 16'(LPM_FULL_HALT), 16'(state_q));
    @(posedge core_clk);
    ext_irq <= 1'b1;
    wait_run(n);
    full_n = n;
    chk("full wake", 16'h1, 16'(n >= FULL_CYC + 1 && n <= FULL_CYC + 2));
    chk("run clocks", 16'h1fff, 16'(clk_en_q));
    @(posedge core_clk);
    ext_irq <= 1'b0;
    any_irq <= 1'b0;
    $display("test full_halt done");
  endtask

  task automatic t_osc;
    int n;
    u_core.set_sel(1'b1);
    for (int k = 0; k < 2; k++) begin
      // first pass keeps the tick unit, second the watchdog
      @(posedge core_clk);
      tick_keep <= (k == 0);
      wdog_keep <= (k == 1);
      u_core.pulse(1'b1);
      #1;
      chk("kept state", 16'(LPM_OSC_HALT), 16'(state_q));
      chk("kept clocks", (k == 0) ? 16'h1200 : 16'h1100, 16'(clk_en_q));
      @(posedge core_clk);
      any_irq <= 1'b1;
      wait_run(n);
      chk("kept wake", 16'h1, 16'(n >= KEPT_CYC + 1 && n <= KEPT_CYC + 2 && n < full_n));
      @(posedge core_clk);
      any_irq <= 1'b0;
    end
    $display("test osc_halt done");
  endtask

  task automatic t_idle;
    @(posedge core_clk);
    gate <= 8'h0f;
    u_core.pulse(1'b0);
    #1;
    chk("idle state", 16'(LPM_IDLE), 16'(state_q));
    chk("idle bus", 16'h1, 16'(bus_hold_q));
    chk("idle clocks", 16'h1bf0, 16'(clk_en_q));
    @(posedge core_clk);
    gate <= 8'h3c;
    tick(1);
    chk("idle gate", 16'h1bc3, 16'(clk_en_q));
    @(posedge core_clk);
    any_irq <= 1'b1;
    tick(1);
    chk("idle exit", 16'h0, 16'(bus_hold_q));
    @(posedge core_clk);
    any_irq <= 1'b0;
    $display("test idle done");
  endtask

  task automatic t_sources;
    logic [2:0] src [3] = '{3'b000, 3'b110, 3'b101};
    for (int i = 0; i < 3; i++) begin
      u_core.pulse(1'b1);
      @(posedge core_clk);
      rst_req <= lpm_rst_req_type'(src[i]);
      tick(2);
      chk("reset out", 16'h1, 16'(sys_rst_q));
      chk("reset state", 16'(LPM_RUN), 16'(state_q));
      chk("reset clocks", 16'h1fff, 16'(clk_en_q));
      chk("ram kept", 16'h0, 16'(ram_clear_q));
      @(posedge core_clk);
      rst_req <= lpm_rst_req_type'(3'b100);
      tick(2);
      chk("reset off", 16'h0, 16'(sys_rst_q));
    end
    $display("test sources done");
  endtask

  task automatic t_secure;
    for (int v = 1; v >= 0; v--) begin
      @(posedge core_clk);
      nv_unsecured <= v[0];
      rst <= 1'b1;
      @(posedge core_clk);
      rst <= 1'b0;
      tick(1);
      chk("secured", 16'(!v[0]), 16'(secured_q));
    end
    $display("test secure done");
  endtask

  initial begin
    rst = 1'b1;
    rst_req = lpm_rst_req_type'(3'b100);
    ext_irq = 1'b0;
    any_irq = 1'b0;
    tick_keep = 1'b1;
    wdog_keep = 1'b0;
    nv_unsecured = 1'b0;
    gate = 8'h00;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    tick(1);
    chk("start state", 16'(LPM_RUN), 16'(state_q));
    chk("start secured", 16'h1, 16'(secured_q));
    t_full();
    t_sources();
    t_osc();
    t_idle();
    t_secure();
    report_and_stop();
  end
endmodule

`default_nettype wire
